// File: logic/hbg_pkg.sv
// hbg_pkg: shared constants, types and apb register map for the h-bridge gate control block
// assumes a 40 mhz system clock and a 32-bit apb master
package hbg_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    // interval lengths in nanoseconds
    localparam int unsigned TOFF_NS = 25_000;
    localparam int unsigned BLANK_NS = 2_000;
    localparam int unsigned DRIVE_NS = 1_000;
    localparam int unsigned DEAD_NS = 250;
    localparam int unsigned TOFF_CYC = (TOFF_NS * 40) / 1000;
    localparam int unsigned BLANK_CYC = (BLANK_NS * 40) / 1000;
    localparam int unsigned DRIVE_CYC = (DRIVE_NS * 40) / 1000;
    localparam int unsigned DEAD_CYC = (DEAD_NS * 40 + 999) / 1000;
    localparam int unsigned CNT_W = 12;
    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    // control register fields
    localparam int unsigned CTRL_SH_BIT = 0;
    localparam int unsigned CTRL_GAIN_LSB = 1;
    localparam int unsigned CTRL_STR_LSB = 3;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // status register fields
    localparam int unsigned STAT_MODE_LSB = 0;
    localparam int unsigned STAT_FAULT_BIT = 2;
    localparam int unsigned STAT_CHOP_BIT = 3;
    localparam int unsigned STAT_GATE_LSB = 4;
    // strap decoding for gate strength: low gives the weakest, open gives intermediate
    localparam logic [2:0] STR_WEAK = 3'h0;
    localparam logic [2:0] STR_OPEN = 3'h3;
    localparam logic [2:0] STR_HIGH = 3'h5;

    typedef enum logic [1:0]
    {
        HBG_M_DIREN = 2'h0,
        HBG_M_INDEP = 2'h1,
        HBG_M_PWM = 2'h3
    } hbg_mode_t;

    typedef enum logic [1:0]
    {
        HBG_C_DRIVE = 2'h0,
        HBG_C_BLANK = 2'h1,
        HBG_C_OFF = 2'h3
    } hbg_chop_t;

    // gate command {high_1, low_1, high_2, low_2}
    localparam logic [3:0] G_OFF = 4'h0;
    localparam logic [3:0] G_FWD = 4'h9;
    localparam logic [3:0] G_REV = 4'h6;
    localparam logic [3:0] G_BRK = 4'h5;
endpackage

// File: logic/hbg_gate_ctrl.sv
// hbg_gate_ctrl: control logic of one h-bridge gate driver with apb configuration and status
// assumes synchronous inputs, analog comparators delivered as logic levels, host strap pins
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module hbg_gate_ctrl
    import hbg_pkg::*;
#(
    parameter int unsigned TOFF_CYCLES = TOFF_CYC,
    parameter int unsigned BLANK_CYCLES = BLANK_CYC,
    parameter int unsigned DRIVE_CYCLES = DRIVE_CYC,
    parameter int unsigned DEAD_CYCLES = DEAD_CYC,
    parameter bit CONFIGURABLE = 1'b1
)
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic first_control_input_i,
    input wire logic second_control_input_i,
    input wire logic sleep_bar_i,
    input wire logic mode_strap_high_i,
    input wire logic mode_strap_open_i,
    input wire logic strength_strap_low_i,
    input wire logic strength_strap_open_i,
    input wire logic chop_trip_i,
    input wire logic sense_over_1v_i,
    input wire logic other_fault_i,
    input wire logic [3:0] gate_is_on_i,
    output logic digital_supply_o,
    output logic analog_supply_o,
    output logic bridge_enable_o,
    output logic [3:0] gate_cmd_o,
    output logic [3:0] strong_pulldown_o,
    output logic [3:0] peak_drive_o,
    output logic [2:0] gate_strength_select_o,
    output logic [1:0] amp_gain_o,
    output logic amp_out_enable_o,
    output logic fault_out_n_o,
    output logic fault_out_n_oe_o
);
    typedef struct packed {
        logic rs1;
        logic rs2;
        logic [1:0] pwr_seq;
        hbg_mode_t mode;
        logic sleep_d;
        hbg_chop_t chop;
        logic [CNT_W-1:0] chop_cnt;
        logic [CNT_W-1:0] drv_cnt;
        logic [CNT_W-1:0] dead_cnt;
        logic [3:0] want;
        logic [3:0] gate;
        logic [3:0] pull;
        logic [3:0] peak;
        logic [2:0] strength;
        logic [31:0] ctrl;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic amp_en;
        logic fault;
    } hbg_state_t;

    hbg_state_t st_r;
    hbg_state_t st_nxt;
    logic rs1_r;
    logic rs2_r;
    logic rst_n;

    // two-flop reset release; rest of the design uses the released copy
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rs1_r <= 1'b0;
            rs2_r <= 1'b0;
        end
        else
        begin
            rs1_r <= 1'b1;
            rs2_r <= rs1_r;
        end
    end
    assign rst_n = rs2_r;

    // gate pattern from mode and inputs, no chopping involved
    function automatic logic [3:0] decode(input hbg_mode_t m, input logic a, input logic b);
        logic [3:0] g;
        g = G_OFF;
        unique case (m)
            HBG_M_DIREN: g = !b ? G_BRK : (a ? G_FWD : G_REV);
            HBG_M_INDEP: g = {a, !a, b, !b};
            HBG_M_PWM: g = ({a, b} == 2'b00) ? G_OFF : ({a, b} == 2'b01) ? G_REV :
                           ({a, b} == 2'b10) ? G_FWD : G_BRK;
            default: g = G_OFF;
        endcase
        return g;
    endfunction

    function automatic logic [CNT_W-1:0] cnt_of(input int unsigned n);
        return CNT_W'(n);
    endfunction

    always_comb
    begin
        logic driving;
        logic [3:0] target;
        logic [3:0] opp_on;
        logic [3:0] turning_on;
        logic apb_acc;
        st_nxt = st_r;
        driving = 1'b0;
        target = G_OFF;
        opp_on = 4'h0;
        turning_on = 4'h0;
        apb_acc = psel_i && penable_i;
        st_nxt.sleep_d = sleep_bar_i;

        // power sequencing: digital first, then mode latch, then analog
        if (!sleep_bar_i)
        begin
            st_nxt.pwr_seq = 2'h0;
        end
        else if (st_r.pwr_seq != 2'h3)
        begin
            st_nxt.pwr_seq = st_r.pwr_seq + 2'h1;
        end
        // strap captured only in the step between the two supply enables
        if (sleep_bar_i && st_r.pwr_seq == 2'h1)
        begin
            st_nxt.mode = mode_strap_open_i ? HBG_M_PWM :
                          (mode_strap_high_i ? HBG_M_INDEP : HBG_M_DIREN);
            st_nxt.strength = strength_strap_low_i ? STR_WEAK :
                              (strength_strap_open_i ? STR_OPEN : STR_HIGH);
        end

        st_nxt.want = decode(st_r.mode, first_control_input_i, second_control_input_i);
        driving = (st_nxt.want == G_FWD) || (st_nxt.want == G_REV);

        // fixed off-time chopping with blanking, counted on the device clock
        unique case (st_r.chop)
            HBG_C_DRIVE:
            begin
                if (driving && st_r.want != st_nxt.want)
                begin
                    st_nxt.chop = HBG_C_BLANK;
                    st_nxt.chop_cnt = cnt_of(BLANK_CYCLES);
                end
                else if (driving && chop_trip_i && st_r.mode != HBG_M_INDEP)
                begin
                    st_nxt.chop = HBG_C_OFF;
                    st_nxt.chop_cnt = cnt_of(TOFF_CYCLES);
                end
            end
            HBG_C_BLANK:
            begin
                if (!driving)
                    st_nxt.chop = HBG_C_DRIVE;
                else if (st_r.chop_cnt <= cnt_of(1))
                    st_nxt.chop = HBG_C_DRIVE;
                else
                    st_nxt.chop_cnt = st_r.chop_cnt - cnt_of(1);
            end
            HBG_C_OFF:
            begin
                if (!driving || st_r.chop_cnt <= cnt_of(1))
                begin
                    st_nxt.chop = driving ? HBG_C_BLANK : HBG_C_DRIVE;
                    st_nxt.chop_cnt = cnt_of(BLANK_CYCLES);
                end
                else
                    st_nxt.chop_cnt = st_r.chop_cnt - cnt_of(1);
            end
            default: st_nxt.chop = HBG_C_DRIVE;
        endcase
        if (st_r.pwr_seq != 2'h3 || st_r.mode == HBG_M_INDEP)
            st_nxt.chop = HBG_C_DRIVE;
        target = (st_nxt.chop == HBG_C_OFF) ? G_BRK : st_nxt.want;
        if (st_r.pwr_seq != 2'h3)
            target = G_OFF;

        // break-before-make per half-bridge: opposite gate must report off first
        opp_on = {gate_is_on_i[2], gate_is_on_i[3], gate_is_on_i[0], gate_is_on_i[1]};
        for (int i = 0; i < 4; i++)
        begin
            if (!target[i])
                st_nxt.gate[i] = 1'b0;
            else if (!st_r.gate[i] && !opp_on[i] && !st_r.gate[i ^ 1] && st_r.dead_cnt == '0)
                st_nxt.gate[i] = 1'b1;
        end
        if (st_nxt.gate != st_r.gate && st_nxt.gate == st_r.gate)
            st_nxt.dead_cnt = '0;
        else if ((st_r.gate & ~target) != 4'h0)
            st_nxt.dead_cnt = cnt_of(DEAD_CYCLES);
        else if (st_r.dead_cnt != '0)
            st_nxt.dead_cnt = st_r.dead_cnt - cnt_of(1);

        // peak current for the drive interval after any gate change, then hold current
        turning_on = st_nxt.gate & ~st_r.gate;
        if (st_nxt.gate != st_r.gate)
        begin
            st_nxt.drv_cnt = cnt_of(DRIVE_CYCLES);
            st_nxt.peak = 4'hf;
        end
        else if (st_r.drv_cnt > cnt_of(1))
            st_nxt.drv_cnt = st_r.drv_cnt - cnt_of(1);
        else
        begin
            st_nxt.drv_cnt = '0;
            st_nxt.peak = 4'h0;
        end
        // strong pulldown on the low gate while its high gate turns on
        st_nxt.pull = {1'b0, turning_on[3] || (st_r.peak[3] && st_r.gate[3]),
                       1'b0, turning_on[1] || (st_r.peak[1] && st_r.gate[1])};

        // amplifier output off in brake when hold-sample mode is set
        st_nxt.amp_en = (st_r.pwr_seq == 2'h3) &&
                        !(st_r.ctrl[CTRL_SH_BIT] && target == G_BRK);
        st_nxt.fault = sense_over_1v_i || other_fault_i;

        // apb slave, zero wait states; unmapped offsets answer with an error
        st_nxt.ready = 1'b0;
        st_nxt.slverr = 1'b0;
        if (psel_i && !penable_i)
        begin
            st_nxt.ready = 1'b1;
            st_nxt.slverr = !(paddr_i == OFS_CTRL || paddr_i == OFS_STAT);
            st_nxt.rdata = 32'h0000_0000;
            if (!pwrite_i && paddr_i == OFS_CTRL)
                st_nxt.rdata = st_r.ctrl;
            if (!pwrite_i && paddr_i == OFS_STAT)
            begin
                st_nxt.rdata[STAT_MODE_LSB +: 2] = st_r.mode;
                st_nxt.rdata[STAT_FAULT_BIT] = st_r.fault;
                st_nxt.rdata[STAT_CHOP_BIT] = (st_r.chop == HBG_C_OFF);
                st_nxt.rdata[STAT_GATE_LSB +: 4] = st_r.gate;
            end
        end
        if (apb_acc && st_r.ready && pwrite_i && paddr_i == OFS_CTRL)
        begin
            st_nxt.ctrl = 32'h0000_0000;
            st_nxt.ctrl[CTRL_SH_BIT] = pwdata_i[CTRL_SH_BIT];
            st_nxt.ctrl[CTRL_GAIN_LSB +: 2] = CONFIGURABLE ? pwdata_i[CTRL_GAIN_LSB +: 2] : 2'h1;
        end
        if (apb_acc && st_r.ready)
            st_nxt.ready = 1'b0;
        st_nxt.rs1 = 1'b0;
        st_nxt.rs2 = 1'b0;
    end

    // single state register
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            st_r.mode <= HBG_M_DIREN;
            st_r.chop <= HBG_C_DRIVE;
            st_r.ctrl <= CTRL_RST;
        end
        else
            st_r <= st_nxt;
    end

    assign prdata_o = st_r.rdata;
    assign pready_o = st_r.ready;
    assign pslverr_o = st_r.slverr;
    assign digital_supply_o = st_r.pwr_seq != 2'h0;
    assign analog_supply_o = st_r.pwr_seq == 2'h3;
    assign bridge_enable_o = st_r.pwr_seq == 2'h3;
    assign gate_cmd_o = st_r.gate;
    assign strong_pulldown_o = st_r.pull;
    assign peak_drive_o = st_r.peak;
    assign gate_strength_select_o = st_r.strength;
    assign amp_gain_o = st_r.ctrl[CTRL_GAIN_LSB +: 2];
    assign amp_out_enable_o = st_r.amp_en;
    assign fault_out_n_o = 1'b0;
    assign fault_out_n_oe_o = st_r.fault;
endmodule

// File: sim/hbg_fet_model.sv
// hbg_fet_model: external bridge fets, reports which gates are on
// assumes gate commands from the block; a gate settles one or two clocks after its command
`timescale 1ns/100ps
module hbg_fet_model
#(
    parameter bit SLOW = 1'b1
)
(
    input wire logic clock_i,
    input wire logic [3:0] gate_cmd_o,
    input wire logic bridge_enable_o,
    output logic [3:0] gate_is_on_i
);
    logic [3:0] stage_r = 4'h0;
    initial gate_is_on_i = 4'h0;
    // gate charge lag; a disabled bridge leaves every fet off
    always @(posedge clock_i)
    begin
        stage_r <= gate_cmd_o & {4{bridge_enable_o}};
        gate_is_on_i <= SLOW ? stage_r : gate_cmd_o & {4{bridge_enable_o}};
    end
endmodule

// File: sim/hbg_gate_ctrl_properties.sv
// hbg_gate_ctrl_props: timing relations at the ports of the gate control block
// assumes one clock domain and the top module's port names
`timescale 1ns/100ps
module hbg_gate_ctrl_props
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic sleep_bar_i,
    input wire logic sense_over_1v_i,
    input wire logic other_fault_i,
    input wire logic [3:0] gate_is_on_i,
    input wire logic digital_supply_o,
    input wire logic analog_supply_o,
    input wire logic bridge_enable_o,
    input wire logic [3:0] gate_cmd_o,
    input wire logic [3:0] strong_pulldown_o,
    input wire logic [3:0] peak_drive_o,
    input wire logic fault_out_n_o,
    input wire logic fault_out_n_oe_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // margins allow for the single register stage between inputs and outputs
    fault_pull_a: assert property ((sense_over_1v_i || other_fault_i) |-> ##[1:4] fault_out_n_oe_o)
        else $error("fault line not pulled");
    fault_free_a: assert property ((!sense_over_1v_i && !other_fault_i) [*4] |-> !fault_out_n_oe_o)
        else $error("fault line held without fault");
    fault_level_a: assert property (!fault_out_n_o)
        else $error("fault line driven high");
    sleep_off_a: assert property (!sleep_bar_i |-> ##[1:2] !(bridge_enable_o || analog_supply_o || digital_supply_o))
        else $error("outputs alive in sleep");
    supply_order_a: assert property ($rose(analog_supply_o) |-> $past(digital_supply_o, 2))
        else $error("analog supply before digital");
    no_shoot_a: assert property (!(gate_cmd_o[3] && gate_cmd_o[2]) && !(gate_cmd_o[1] && gate_cmd_o[0]))
        else $error("both gates of a half-bridge on");
    handshake_a: assert property (($rose(gate_cmd_o[3]) |-> !$past(gate_is_on_i[2]))
        and ($rose(gate_cmd_o[2]) |-> !$past(gate_is_on_i[3])))
        else $error("gate on before opposite off");
    pulldown_a: assert property ($rose(gate_cmd_o[3]) |-> ##[0:2] strong_pulldown_o[2])
        else $error("no strong pulldown at high-side turn on");
    peak_a: assert property ($changed(gate_cmd_o) |-> ##[0:1] (peak_drive_o != 4'h0))
        else $error("no peak drive on gate change");
endmodule
bind hbg_gate_ctrl hbg_gate_ctrl_props chk_u (.clock_i, .rstn_i, .sleep_bar_i, .sense_over_1v_i, .other_fault_i,
    .gate_is_on_i, .digital_supply_o, .analog_supply_o, .bridge_enable_o, .gate_cmd_o, .strong_pulldown_o,
    .peak_drive_o, .fault_out_n_o, .fault_out_n_oe_o);

// File: sim/testbench.sv
// testbench: drives the gate control block through apb, straps and control inputs
// assumes the fet model for gate feedback and shortened interval parameters
`timescale 1ns/100ps
module testbench;
    import hbg_pkg::*;
    logic clock_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, e;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, q;
    logic first_control_input_i = 0, second_control_input_i = 0, sleep_bar_i = 0;
    logic mode_strap_high_i = 0, mode_strap_open_i = 0, strength_strap_low_i = 0, strength_strap_open_i = 0;
    logic chop_trip_i = 0, sense_over_1v_i = 0, other_fault_i = 0, pready_o, pslverr_o;
    logic digital_supply_o, analog_supply_o, bridge_enable_o, amp_out_enable_o, fault_out_n_o, fault_out_n_oe_o;
    logic [3:0] gate_is_on_i, gate_cmd_o, strong_pulldown_o, peak_drive_o;
    logic [2:0] gate_strength_select_o;
    logic [1:0] amp_gain_o;
    int fails = 0, compares = 0, n;
    // expected gates per mode and input pair {first, second}
    logic [3:0] exp_g [3][4] = '{'{G_BRK, G_REV, G_BRK, G_FWD}, '{G_BRK, G_REV, G_FWD, 4'ha},
        '{G_OFF, G_REV, G_FWD, G_BRK}};
    logic [1:0] exp_m [3] = '{2'h0, 2'h1, 2'h3};
    logic [2:0] exp_s [3] = '{STR_WEAK, STR_OPEN, STR_HIGH};

    // blanking and off-time outlast the gate feedback lag so the drive state is seen before a chop
    hbg_gate_ctrl #(.TOFF_CYCLES(12), .BLANK_CYCLES(8), .DRIVE_CYCLES(2), .DEAD_CYCLES(1)) dut_u
    (
        .clock_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
        .pslverr_o, .first_control_input_i, .second_control_input_i, .sleep_bar_i, .mode_strap_high_i,
        .mode_strap_open_i, .strength_strap_low_i, .strength_strap_open_i, .chop_trip_i, .sense_over_1v_i,
        .other_fault_i, .gate_is_on_i, .digital_supply_o, .analog_supply_o, .bridge_enable_o, .gate_cmd_o,
        .strong_pulldown_o, .peak_drive_o, .gate_strength_select_o, .amp_gain_o, .amp_out_enable_o,
        .fault_out_n_o, .fault_out_n_oe_o
    );
    hbg_fet_model #(.SLOW(1'b1)) fet_u (.clock_i, .gate_cmd_o, .bridge_enable_o, .gate_is_on_i);

    initial forever #12.5 clock_i = ~clock_i;

    task chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want)
        begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task print_verdict();
        if (fails == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // one apb transfer; request held until pready is sampled high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        n = 0;
        do
            @(posedge clock_i);
        while (pready_o !== 1'b1 && ++n < 50);
        q = prdata_o;
        e = pslverr_o;
        chk(n < 50, 1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // gates pass through dead time, so wait for the settled command
    task wg(input logic [3:0] want);
        n = 0;
        while (gate_cmd_o !== want && n < 40)
        begin
            @(posedge clock_i);
            n++;
        end
        chk(gate_cmd_o, want);
    endtask

    // leave sleep; digital supply comes up one edge later, analog supply and bridge enable three edges later
    task wake();
        @(posedge clock_i);
        sleep_bar_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        chk({digital_supply_o, analog_supply_o, bridge_enable_o}, 3'h7);
    endtask

    initial
    begin
        repeat (3) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk({digital_supply_o, gate_cmd_o, fault_out_n_oe_o}, 6'h0);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(q, CTRL_RST);
        for (int m = 0; m < 3; m++)
        begin
            @(posedge clock_i);
            sleep_bar_i <= 1'b0;
            mode_strap_high_i <= (m == 1);
            mode_strap_open_i <= (m == 2);
            strength_strap_low_i <= (m == 0);
            strength_strap_open_i <= (m == 1);
            repeat (2) @(posedge clock_i);
            chk({analog_supply_o, bridge_enable_o}, 2'h0);
            wake();
            chk(gate_strength_select_o, exp_s[m]);
            // strap moves after the latch and must be ignored
            mode_strap_high_i <= (m != 1);
            mode_strap_open_i <= (m != 2);
            for (int p = 0; p < 4; p++)
            begin
                first_control_input_i <= p[1];
                second_control_input_i <= p[0];
                wg(exp_g[m][p]);
            end
            apb(1'b0, OFS_STAT, 32'h0);
            chk(q[1:0], exp_m[m]);
        end
        for (int g = 3; g >= 0; g--)
        begin
            apb(1'b1, OFS_CTRL, {29'h0, g[1:0], 1'b1});
            apb(1'b0, OFS_CTRL, 32'h0);
            chk(q, {29'h0, g[1:0], 1'b1});
            chk(amp_gain_o, g[1:0]);
        end
        apb(1'b1, 8'h08, 32'h0);
        chk(e, 1'b1);
        // trip present from drive start is masked by blanking, then brakes
        chop_trip_i <= 1'b1;
        first_control_input_i <= 1'b1;
        second_control_input_i <= 1'b0;
        wg(G_FWD);
        wg(G_BRK);
        @(posedge clock_i);
        chk(amp_out_enable_o, 1'b0);
        chop_trip_i <= 1'b0;
        for (n = 0; gate_cmd_o === G_BRK && n < 40; n++)
            @(posedge clock_i);
        chk(n > 1 && n < 40, 1);
        wg(G_FWD);
        @(posedge clock_i);
        chk(amp_out_enable_o, 1'b1);
        // independent mode ignores the comparator
        @(posedge clock_i);
        sleep_bar_i <= 1'b0;
        mode_strap_high_i <= 1'b1;
        mode_strap_open_i <= 1'b0;
        wake();
        chop_trip_i <= 1'b1;
        repeat (20) @(posedge clock_i);
        chk(gate_cmd_o, G_FWD);
        chop_trip_i <= 1'b0;
        sense_over_1v_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        chk({fault_out_n_oe_o, fault_out_n_o}, 2'h2);
        sense_over_1v_i <= 1'b0;
        other_fault_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        chk(fault_out_n_oe_o, 1'b1);
        other_fault_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        chk(fault_out_n_oe_o, 1'b0);
        print_verdict();
    end

    // watchdog well past the expected run of a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge clock_i);
        fails++;
        print_verdict();
    end
endmodule
